//--- logic/acd_comparator.sv
// digital control of one analog comparator with an axi4-lite register port
// Operation
// [R1] enable bit powers the comparator; cleared means lowest-current off state
// [R2] result readable in control register a and the shared mirror register
// [R3] software routes result to a pin via output select and direction bit; here pin_result always follows gate_source, with no select or direction bit
// [R4] raw result sampled into a register once per instruction cycle
// [R5] invert select zero passes plus-greater-than-minus; one complements it
// [R6] hysteresis select bit drives the hysteresis control of the front end
// [R7] result offered as gate source for the gate timer
// [R8] software should enable timer synchronisation for clean gating
// [R9] sync mode captures result on falling edge of prescaled timer clock
// [R10] gate timer advances on rising edge, opposite the capture edge
// [R11] rising and falling edges detected separately, each with own enable
// [R12] only software clears event flag; a simultaneous edge keeps it set
// [R13] edges seen after polarity and enable gating, so toggling raises events
// [R14] interrupt needs event enable, peripheral gate and global gate
// [R15] three-bit selector routes plus input to pins, converter, reference, ground
// [R16] three-bit selector routes minus input to pins, reference, ground
// [R17] all inputs disconnected while the enable bit is cleared
// [R18] active result with shutdown source enabled suspends waveform generator one
// [R19] operates in sleep; sync path stops if timer runs on system clocks
// [R20] comparator interrupt wakes device when event enable is set
// [R21] minus codes: 7 ground, 6 reference, 5 and 4 open, 3..0 pins
// [R22] plus codes: 7 ground, 6 reference, 5 converter, 4..2 open, 1..0 pins
// [R23] mirror register bit 0 this comparator, bit 1 the second one
// [R24] edges found by comparing current and previous sampled result
`timescale 1ns/100ps
`default_nettype none
module acd_comparator (
  input  wire logic                aclk,
  input  wire logic                aresetn,
  // axi4-lite slave
  input  wire logic [7:0]          s_axi_awaddr,
  input  wire logic                s_axi_awvalid,
  output logic                     s_axi_awready,
  input  wire logic [31:0]         s_axi_wdata,
  input  wire logic [3:0]          s_axi_wstrb,
  input  wire logic                s_axi_wvalid,
  output logic                     s_axi_wready,
  output logic [1:0]               s_axi_bresp,
  output logic                     s_axi_bvalid,
  input  wire logic                s_axi_bready,
  input  wire logic [7:0]          s_axi_araddr,
  input  wire logic                s_axi_arvalid,
  output logic                     s_axi_arready,
  output logic [31:0]              s_axi_rdata,
  output logic [1:0]               s_axi_rresp,
  output logic                     s_axi_rvalid,
  input  wire logic                s_axi_rready,
  // analog side
  input  wire logic                analog_greater,
  input  wire logic                other_mirror_bit,
  output acd_pkg::acd_analog_s     analog_ctrl,
  // gate timer side
  input  wire logic                timer_clk_pre,
  input  wire logic                timer_on_sysclk,
  output logic                     gate_source,
  output logic                     timer_count_en,
  // system side
  output logic                     pin_result,
  output logic                     shutdown_req,
  output logic                     irq_req,
  output logic                     wake_req
);
  import acd_pkg::*;

  typedef enum logic [2:0] {
    ACD_W_IDLE = 3'b001,
    ACD_W_RESP = 3'b010,
    ACD_W_HOLD = 3'b100
  } acd_wst_e;

  logic [7:0] ctrl_a_q;
  logic [1:0] ctrl_b_q;
  logic [2:0] nsel_q;
  logic [2:0] psel_q;
  logic       event_en_q;
  logic [3:0] sys_q;
  logic       flag_q;
  logic [1:0] div_q;
  logic       instr_tick;
  logic       cmp_q;
  logic       cmp_prev_q;
  logic       ana_s1_q;
  logic       ana_s2_q;
  logic       tclk_s1_q;
  logic       tclk_s2_q;
  logic       tclk_d3_q;
  logic       sync_q;
  logic       gated;
  logic       rise_ev;
  logic       fall_ev;
  logic       edge_set;
  logic       sync_run;
  logic       tclk_fall;
  logic       tclk_rise;
  acd_wst_e   wst_q;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic       aw_have_q;
  logic       w_have_q;
  logic       wr_fire;
  logic       wr_bad;
  logic       flag_clr;
  logic [31:0] rd_word;
  logic       rd_bad;

  // instruction-cycle enable
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_q <= 2'h0;
    end else begin
      div_q <= div_q + 2'h1;
    end
  end
  assign instr_tick = (div_q == INSTR_LAST);

  // analog comparator output is asynchronous to aclk
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ana_s1_q <= 1'b0;
      ana_s2_q <= 1'b0;
      tclk_s1_q <= 1'b0;
      tclk_s2_q <= 1'b0;
      tclk_d3_q <= 1'b0;
    end else begin
      ana_s1_q <= analog_greater;
      ana_s2_q <= ana_s1_q;
      tclk_s1_q <= timer_clk_pre;
      tclk_s2_q <= tclk_s1_q;
      tclk_d3_q <= tclk_s2_q;
    end
  end

  // disabled comparator reads low before polarity, so toggling either still gives an edge
  assign gated = (ctrl_a_q[CA_ENABLE] & ana_s2_q) ^ ctrl_a_q[CA_INVERT]; // [R5] [R13] [R1]

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cmp_q <= 1'b0;
      cmp_prev_q <= 1'b0;
    end else if (instr_tick) begin
      cmp_q <= gated; // [R4]
      cmp_prev_q <= cmp_q; // [R24]
    end
  end

  assign rise_ev = instr_tick & cmp_q & ~cmp_prev_q; // [R11] [R24]
  assign fall_ev = instr_tick & ~cmp_q & cmp_prev_q; // [R11]
  assign edge_set = (rise_ev & ctrl_b_q[CB_RISE]) | (fall_ev & ctrl_b_q[CB_FALL]); // [R11]

  // timer clock edges, prescaled clock arrives from the timer
  assign tclk_fall = tclk_d3_q & ~tclk_s2_q;
  assign tclk_rise = ~tclk_d3_q & tclk_s2_q;
  // system-clocked timer halts in sleep, so the sync path freezes too
  assign sync_run = ~(sys_q[SY_SLEEP] & timer_on_sysclk); // [R19]

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync_q <= 1'b0;
    end else if (tclk_fall && sync_run) begin
      sync_q <= cmp_q; // [R9]
    end
  end

  assign gate_source = ctrl_a_q[CA_SYNC] ? sync_q : cmp_q; // [R7] [R9]
  assign timer_count_en = tclk_rise & sync_run; // [R10]
  assign pin_result = gate_source; // [R3]
  assign shutdown_req = cmp_q & sys_q[SY_SDEN]; // [R18]
  assign irq_req = flag_q & event_en_q & sys_q[SY_PERIPHERAL_IRQ_GATE] & sys_q[SY_GIE]; // [R14]
  assign wake_req = flag_q & event_en_q & sys_q[SY_SLEEP]; // [R20] [R19]

  always_comb begin
    analog_ctrl = '0;
    analog_ctrl.power_on = ctrl_a_q[CA_ENABLE]; // [R1]
    analog_ctrl.hysteresis = ctrl_a_q[CA_ENABLE] & ctrl_a_q[CA_HYST]; // [R6]
    if (ctrl_a_q[CA_ENABLE]) begin // [R17]
      if (nsel_q == NSEL_AGND) begin // [R16] [R21]
        analog_ctrl.minus_route[5] = 1'b1;
      end else if (nsel_q == NSEL_REF2) begin
        analog_ctrl.minus_route[4] = 1'b1;
      end else if (nsel_q != NSEL_NC5 && nsel_q != NSEL_NC4) begin
        analog_ctrl.minus_route[nsel_q[1:0]] = 1'b1;
      end
      if (psel_q == PSEL_AGND) begin // [R15] [R22]
        analog_ctrl.plus_route[4] = 1'b1;
      end else if (psel_q == PSEL_REF2) begin
        analog_ctrl.plus_route[3] = 1'b1;
      end else if (psel_q == PSEL_DAC) begin
        analog_ctrl.plus_route[2] = 1'b1;
      end else if (psel_q == PSEL_PIN1) begin
        analog_ctrl.plus_route[1] = 1'b1;
      end else if (psel_q == PSEL_PIN0) begin
        analog_ctrl.plus_route[0] = 1'b1;
      end
    end
  end

  // write channel: address and data accepted in either order
  assign s_axi_awready = (wst_q == ACD_W_IDLE) && !aw_have_q;
  assign s_axi_wready = (wst_q == ACD_W_IDLE) && !w_have_q;
  assign wr_fire = (wst_q == ACD_W_IDLE) && aw_have_q && w_have_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end else if (wr_fire) begin
        aw_have_q <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end else if (wr_fire) begin
        w_have_q <= 1'b0;
      end
    end
  end

  always_comb begin
    wr_bad = 1'b0;
    if (awaddr_q == ADDR_CTRL_A || awaddr_q == ADDR_CTRL_B) begin
      wr_bad = 1'b0;
    end else if (awaddr_q == ADDR_NSEL || awaddr_q == ADDR_PSEL) begin
      wr_bad = 1'b0;
    end else if (awaddr_q == ADDR_FLAGS || awaddr_q == ADDR_IRQ_EN) begin
      wr_bad = 1'b0;
    end else if (awaddr_q == ADDR_SYS || awaddr_q == ADDR_MIRROR) begin
      wr_bad = 1'b0;
    end else begin
      wr_bad = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wst_q <= ACD_W_IDLE;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      case (wst_q)
        ACD_W_IDLE: begin
          if (wr_fire) begin
            wst_q <= ACD_W_RESP;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_bad ? RESP_SLVERR : RESP_OKAY;
          end
        end
        ACD_W_RESP: begin
          if (s_axi_bready) begin
            wst_q <= ACD_W_HOLD;
            s_axi_bvalid <= 1'b0;
          end
        end
        ACD_W_HOLD: begin
          wst_q <= ACD_W_IDLE;
        end
        default: begin
          wst_q <= ACD_W_IDLE;
        end
      endcase
    end
  end

  // control registers, low byte lane only
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_a_q <= CTRL_RESET;
      ctrl_b_q <= 2'h0;
      nsel_q <= SEL_RESET;
      psel_q <= SEL_RESET;
      event_en_q <= 1'b0;
      sys_q <= 4'h0;
    end else if (wr_fire && wstrb_q[0]) begin
      if (awaddr_q == ADDR_CTRL_A) begin
        ctrl_a_q <= wdata_q[7:0] & 8'h93;
      end else if (awaddr_q == ADDR_CTRL_B) begin
        ctrl_b_q <= wdata_q[1:0];
      end else if (awaddr_q == ADDR_NSEL) begin
        nsel_q <= wdata_q[2:0];
      end else if (awaddr_q == ADDR_PSEL) begin
        psel_q <= wdata_q[2:0];
      end else if (awaddr_q == ADDR_IRQ_EN) begin
        event_en_q <= wdata_q[0];
      end else if (awaddr_q == ADDR_SYS) begin
        sys_q <= wdata_q[3:0];
      end
    end
  end

  // writing zero to bit 0 of the flag register clears it
  assign flag_clr = wr_fire && wstrb_q[0] && (awaddr_q == ADDR_FLAGS) && !wdata_q[0];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flag_q <= 1'b0;
    end else if (edge_set) begin
      flag_q <= 1'b1; // [R12]
    end else if (flag_clr) begin
      flag_q <= 1'b0; // [R12]
    end
  end

  // read channel
  always_comb begin
    rd_word = 32'h0000_0000;
    rd_bad = 1'b0;
    if (s_axi_araddr == ADDR_CTRL_A) begin
      rd_word[7:0] = ctrl_a_q;
      rd_word[CA_RESULT] = cmp_q; // [R2]
    end else if (s_axi_araddr == ADDR_CTRL_B) begin
      rd_word[1:0] = ctrl_b_q;
    end else if (s_axi_araddr == ADDR_NSEL) begin
      rd_word[2:0] = nsel_q;
    end else if (s_axi_araddr == ADDR_PSEL) begin
      rd_word[2:0] = psel_q;
    end else if (s_axi_araddr == ADDR_MIRROR) begin
      rd_word[1:0] = {other_mirror_bit, cmp_q}; // [R2] [R23]
    end else if (s_axi_araddr == ADDR_FLAGS) begin
      rd_word[0] = flag_q;
    end else if (s_axi_araddr == ADDR_IRQ_EN) begin
      rd_word[0] = event_en_q;
    end else if (s_axi_araddr == ADDR_SYS) begin
      rd_word[3:0] = sys_q;
    end else begin
      rd_bad = 1'b1;
    end
  end

  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_word;
      s_axi_rresp <= rd_bad ? RESP_SLVERR : RESP_OKAY;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  a_flag_set_wins: assert property (@(posedge aclk) disable iff (!aresetn)
    edge_set |=> flag_q) else $error("edge lost against flag clear"); // [R12]
  a_flag_clear_sw: assert property (@(posedge aclk) disable iff (!aresetn)
    (flag_q && !flag_clr) |=> flag_q) else $error("flag fell without clear"); // [R12]
  a_sample_tick: assert property (@(posedge aclk) disable iff (!aresetn)
    !instr_tick |=> $stable(cmp_q)) else $error("result sampled off tick"); // [R4]
  a_polarity_map: assert property (@(posedge aclk) disable iff (!aresetn)
    (instr_tick && ctrl_a_q[CA_ENABLE]) |=> cmp_q == $past(ana_s2_q ^ ctrl_a_q[CA_INVERT]))
    else $error("polarity wrong"); // [R5]
  a_inputs_off: assert property (@(posedge aclk) disable iff (!aresetn)
    !ctrl_a_q[CA_ENABLE] |-> (analog_ctrl == '0)) else $error("inputs left on"); // [R17] [R1]
  a_rise_flag: assert property (@(posedge aclk) disable iff (!aresetn)
    (rise_ev && ctrl_b_q[CB_RISE]) |=> flag_q) else $error("rising edge missed"); // [R11]
  a_fall_masked: assert property (@(posedge aclk) disable iff (!aresetn)
    (!flag_q && fall_ev && !ctrl_b_q[CB_FALL] && !rise_ev) |=> !flag_q)
    else $error("masked fall set flag"); // [R11]
  a_irq_gates: assert property (@(posedge aclk) disable iff (!aresetn)
    irq_req |-> (flag_q && sys_q[SY_GIE] && sys_q[SY_PERIPHERAL_IRQ_GATE] && event_en_q))
    else $error("irq without gates"); // [R14]
  a_sync_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    !tclk_fall |=> $stable(sync_q)) else $error("sync moved off falling edge"); // [R9]
  a_shutdown_out: assert property (@(posedge aclk) disable iff (!aresetn)
    shutdown_req == (cmp_q && sys_q[SY_SDEN])) else $error("shutdown mismatch"); // [R18]
endmodule
`default_nettype wire

//--- logic/acd_pkg.sv
// shared constants, register map and field layout for the comparator control block
package acd_pkg;
  // axi4-lite byte addresses, one aligned word per register
  localparam logic [7:0] ADDR_CTRL_A   = 8'h00;
  localparam logic [7:0] ADDR_CTRL_B   = 8'h04;
  localparam logic [7:0] ADDR_NSEL     = 8'h08;
  localparam logic [7:0] ADDR_PSEL     = 8'h0c;
  localparam logic [7:0] ADDR_MIRROR   = 8'h10;
  localparam logic [7:0] ADDR_FLAGS    = 8'h14;
  localparam logic [7:0] ADDR_IRQ_EN   = 8'h18;
  localparam logic [7:0] ADDR_SYS      = 8'h1c;
  // comparator_ctrl_a bit positions
  localparam int CA_ENABLE = 7;
  localparam int CA_RESULT = 6;
  localparam int CA_INVERT = 4;
  localparam int CA_HYST   = 1;
  localparam int CA_SYNC   = 0;
  // comparator_ctrl_b bit positions
  localparam int CB_RISE   = 1;
  localparam int CB_FALL   = 0;
  // sys register: peripheral gate, global gate, shutdown source enable, sleep
  localparam int SY_PERIPHERAL_IRQ_GATE   = 0;
  localparam int SY_GIE    = 1;
  localparam int SY_SDEN   = 2;
  localparam int SY_SLEEP  = 3;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [2:0] SEL_RESET  = 3'h0;
  // instruction cycle = 4 system clocks
  localparam int INSTR_DIV = 4;
  localparam logic [1:0] INSTR_LAST = 2'h3;
  // minus input selector codes
  localparam logic [2:0] NSEL_AGND = 3'h7;
  localparam logic [2:0] NSEL_REF2 = 3'h6;
  localparam logic [2:0] NSEL_NC5  = 3'h5;
  localparam logic [2:0] NSEL_NC4  = 3'h4;
  // plus input selector codes
  localparam logic [2:0] PSEL_AGND = 3'h7;
  localparam logic [2:0] PSEL_REF2 = 3'h6;
  localparam logic [2:0] PSEL_DAC  = 3'h5;
  localparam logic [2:0] PSEL_PIN1 = 3'h1;
  localparam logic [2:0] PSEL_PIN0 = 3'h0;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // analog front-end control bundle
  typedef struct packed {
    logic       power_on;
    logic       hysteresis;
    logic [5:0] minus_route;
    logic [4:0] plus_route;
  } acd_analog_s;
endpackage

//--- tb/testbench.sv
// self-checking bench for the comparator control block
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import acd_pkg::*;
  logic        aclk;
  logic        aresetn;
  logic [7:0]  awaddr;
  logic        awvalid;
  logic        awready;
  logic [31:0] wdata;
  logic        wvalid;
  logic        wready;
  logic [1:0]  bresp;
  logic        bvalid;
  logic        bready;
  logic [7:0]  araddr;
  logic        arvalid;
  logic        arready;
  logic [31:0] rdata;
  logic [1:0]  rresp;
  logic        rvalid;
  logic        rready;
  logic        greater;
  logic        other;
  acd_analog_s actl;
  logic        tclk;
  logic        on_sys;
  logic        gate_src;
  logic        cnt_en;
  logic        pin_res;
  logic        sd_req;
  logic        irq;
  logic        wake;
  int          fails;
  int          samples_checked;
  int          cycles;
  int          pulses;
  int          p0;
  logic [1:0]  resp;
  logic [31:0] rd;
  logic        g;
  logic        inv;
  logic        o;

  acd_comparator dut (
    .aclk             (aclk),
    .aresetn          (aresetn),
    .s_axi_awaddr     (awaddr),
    .s_axi_awvalid    (awvalid),
    .s_axi_awready    (awready),
    .s_axi_wdata      (wdata),
    .s_axi_wstrb      (4'hf),
    .s_axi_wvalid     (wvalid),
    .s_axi_wready     (wready),
    .s_axi_bresp      (bresp),
    .s_axi_bvalid     (bvalid),
    .s_axi_bready     (bready),
    .s_axi_araddr     (araddr),
    .s_axi_arvalid    (arvalid),
    .s_axi_arready    (arready),
    .s_axi_rdata      (rdata),
    .s_axi_rresp      (rresp),
    .s_axi_rvalid     (rvalid),
    .s_axi_rready     (rready),
    .analog_greater   (greater),
    .other_mirror_bit (other),
    .analog_ctrl      (actl),
    .timer_clk_pre    (tclk),
    .timer_on_sysclk  (on_sys),
    .gate_source      (gate_src),
    .timer_count_en   (cnt_en),
    .pin_result       (pin_res),
    .shutdown_req     (sd_req),
    .irq_req          (irq),
    .wake_req         (wake)
  );

  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end

  task automatic stop_test();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // watchdog also counts gate timer advance pulses
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cnt_en === 1'b1) pulses <= pulses + 1;
    if (cycles == 30000) begin
      fails++;
      stop_test();
    end
  end

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // both channels offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw_ok;
    logic w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      if (!aw_ok && awready === 1'b1) begin
        aw_ok = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w_ok && wready === 1'b1) begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
      end
    end
    while (bvalid !== 1'b1) @(posedge aclk);
    resp = bresp;
    bready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic rd_reg(input logic [7:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    rd = rdata;
    resp = rresp;
    rready <= 1'b0;
    @(posedge aclk);
  endtask

  // covers sync flops, the instruction tick and the flag update
  task automatic settle();
    repeat (12) @(posedge aclk);
  endtask

  function automatic acd_analog_s exp_actl(logic en, logic hy, logic [2:0] n, logic [2:0] p);
    acd_analog_s s;
    s = '0;
    if (en) begin
      s.power_on = 1'b1;
      s.hysteresis = hy;
      if (n == NSEL_AGND) s.minus_route[5] = 1'b1;
      else if (n == NSEL_REF2) s.minus_route[4] = 1'b1;
      else if (n < 3'h4) s.minus_route[n] = 1'b1;
      if (p == PSEL_AGND) s.plus_route[4] = 1'b1;
      else if (p == PSEL_REF2) s.plus_route[3] = 1'b1;
      else if (p == PSEL_DAC) s.plus_route[2] = 1'b1;
      else if (p < 3'h2) s.plus_route[p] = 1'b1;
    end
    return s;
  endfunction

  function automatic logic [31:0] exp_ca(logic en, logic res, logic iv, logic hy, logic sy);
    return (32'(en) << CA_ENABLE) | (32'(res) << CA_RESULT) | (32'(iv) << CA_INVERT)
           | (32'(hy) << CA_HYST) | (32'(sy) << CA_SYNC);
  endfunction

  initial begin
    {aresetn, awaddr, awvalid, wdata, wvalid, bready} = '0;
    {araddr, arvalid, rready, greater, other, tclk, on_sys} = '0;
    {fails, samples_checked, cycles, pulses} = '0;
    void'($urandom(67777));
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    for (int i = 0; i < 8; i++) begin
      rd_reg(8'(4 * i));
      chk("reset value", 32'h0, rd);
    end
    rd_reg(8'h20);
    chk("unmapped rresp", 32'(RESP_SLVERR), 32'(resp));
    wr(8'h24, 32'h1);
    chk("unmapped bresp", 32'(RESP_SLVERR), 32'(resp));
    wr(ADDR_MIRROR, 32'h3);
    rd_reg(ADDR_MIRROR);
    chk("mirror read only", 32'h0, rd);
    for (int i = 0; i < 16; i++) begin
      wr(ADDR_CTRL_A, exp_ca(i[3], 1'b0, 1'b0, i[0], 1'b0));
      wr(ADDR_NSEL, 32'(i[2:0]));
      wr(ADDR_PSEL, 32'(3'h7 - i[2:0]));
      chk("analog_ctrl", 32'(exp_actl(i[3], i[0], i[2:0], ~i[2:0])), 32'(actl));
    end
    wr(ADDR_SYS, 32'(1 << SY_SDEN));
    for (int i = 0; i < 12; i++) begin
      g = (i < 2) ? 1'(i) : 1'($urandom);
      inv = (i < 2) ? 1'b1 : 1'($urandom);
      o = 1'($urandom);
      greater <= g;
      other <= o;
      wr(ADDR_CTRL_A, exp_ca(1'b1, 1'b0, inv, 1'b0, 1'b0));
      settle();
      chk("gate_source", 32'(g ^ inv), 32'(gate_src));
      chk("pin_result", 32'(g ^ inv), 32'(pin_res));
      chk("shutdown_req", 32'(g ^ inv), 32'(sd_req));
      rd_reg(ADDR_CTRL_A);
      chk("ctrl_a", exp_ca(1'b1, g ^ inv, inv, 1'b0, 1'b0), rd);
      rd_reg(ADDR_MIRROR);
      chk("mirror", 32'({o, g ^ inv}), rd);
    end
    wr(ADDR_SYS, 32'(1 << SY_PERIPHERAL_IRQ_GATE));
    chk("shutdown off", 32'h0, 32'(sd_req));
    greater <= 1'b0;
    wr(ADDR_CTRL_A, exp_ca(1'b1, 1'b0, 1'b0, 1'b0, 1'b0));
    wr(ADDR_CTRL_B, 32'(1 << CB_RISE));
    settle();
    wr(ADDR_FLAGS, 32'h0);
    greater <= 1'b1;
    settle();
    rd_reg(ADDR_FLAGS);
    chk("flag on rise", 32'h1, rd);
    chk("irq without enable", 32'h0, 32'(irq));
    wr(ADDR_IRQ_EN, 32'h1);
    chk("irq without global", 32'h0, 32'(irq));
    wr(ADDR_SYS, 32'((1 << SY_PERIPHERAL_IRQ_GATE) | (1 << SY_GIE)));
    chk("irq", 32'h1, 32'(irq));
    chk("wake awake", 32'h0, 32'(wake));
    wr(ADDR_SYS, 32'((1 << SY_GIE) | (1 << SY_SLEEP)));
    chk("wake", 32'h1, 32'(wake));
    chk("irq without peripheral", 32'h0, 32'(irq));
    wr(ADDR_FLAGS, 32'h0);
    wr(ADDR_FLAGS, 32'h1);
    rd_reg(ADDR_FLAGS);
    chk("flag cleared", 32'h0, rd);
    chk("wake after clear", 32'h0, 32'(wake));
    greater <= 1'b0;
    settle();
    rd_reg(ADDR_FLAGS);
    chk("fall ignored", 32'h0, rd);
    wr(ADDR_CTRL_B, 32'(1 << CB_FALL));
    greater <= 1'b1;
    settle();
    rd_reg(ADDR_FLAGS);
    chk("rise ignored", 32'h0, rd);
    greater <= 1'b0;
    settle();
    rd_reg(ADDR_FLAGS);
    chk("flag on fall", 32'h1, rd);
    wr(ADDR_CTRL_B, 32'h3);
    wr(ADDR_CTRL_A, 32'h0);
    settle();
    wr(ADDR_FLAGS, 32'h0);
    settle();
    wr(ADDR_CTRL_A, exp_ca(1'b0, 1'b0, 1'b1, 1'b0, 1'b0));
    settle();
    rd_reg(ADDR_FLAGS);
    chk("flag while disabled", 32'h1, rd);
    chk("inputs off when disabled", 32'h0, 32'(actl));
    wr(ADDR_SYS, 32'h0);
    wr(ADDR_CTRL_A, exp_ca(1'b1, 1'b0, 1'b0, 1'b0, 1'b1));
    greater <= 1'b1;
    settle();
    tclk <= 1'b1;
    settle();
    chk("sync before fall", 32'h0, 32'(gate_src));
    tclk <= 1'b0;
    settle();
    chk("sync capture", 32'h1, 32'(gate_src));
    greater <= 1'b0;
    p0 = pulses;
    tclk <= 1'b1;
    settle();
    chk("sync hold", 32'h1, 32'(gate_src));
    chk("advance on rise", 32'(p0 + 1), 32'(pulses));
    tclk <= 1'b0;
    settle();
    chk("sync update", 32'h0, 32'(gate_src));
    chk("no advance on fall", 32'(p0 + 1), 32'(pulses));
    on_sys <= 1'b1;
    wr(ADDR_SYS, 32'(1 << SY_SLEEP));
    p0 = pulses;
    greater <= 1'b1;
    tclk <= 1'b1;
    settle();
    tclk <= 1'b0;
    settle();
    chk("sleep stops timer", 32'(p0), 32'(pulses));
    chk("sleep holds sync", 32'h0, 32'(gate_src));
    rd_reg(ADDR_CTRL_A);
    chk("runs in sleep", exp_ca(1'b1, 1'b1, 1'b0, 1'b0, 1'b1), rd);
    stop_test();
  end
endmodule
`default_nettype wire
